// ---- src/rda_top.v ----
// Purpose: status flags, channel sequencer and bus slave of the monitor
// Assumes: conversion engine and limit registers sit outside this block
// Notes:   data line is open drain; oe high pulls the line low
`timescale 1ns/10ps
`include "rda_map.vh"

module rda_top #(
  parameter [6:0] BUS_ADDR = `RDA_ADDR_V99
) (
  input  wire        core_clk_i,
  input  wire        arst_n_i,
  input  wire        smb_clk_i,
  input  wire        smb_data_i,
  output reg         smb_data_oe_o,
  input  wire [5:0]  diode_fault_i,
  input  wire [5:0]  ot_mask_i,
  input  wire [47:0] ot_limit_i,
  input  wire        meas_done_i,
  input  wire [7:0]  meas_temp_i,
  output reg         meas_start_o,
  output reg  [2:0]  meas_chan_o,
  output reg         overtemp_output_oe_o,
  output reg  [7:0]  overtemp_status_o,
  output reg  [7:0]  diode_fault_status_o
);

  localparam [1:0] SQ_PICK = 2'b01;
  localparam [1:0] SQ_WAIT = 2'b10;

  localparam [7:0] SB_IDLE = 8'h01;
  localparam [7:0] SB_ADDR = 8'h02;
  localparam [7:0] SB_ACKA = 8'h04;
  localparam [7:0] SB_WCMD = 8'h08;
  localparam [7:0] SB_ACKC = 8'h10;
  localparam [7:0] SB_RDAT = 8'h20;
  localparam [7:0] SB_RACK = 8'h40;
  localparam [7:0] SB_SKIP = 8'h80;

  // pin synchronisers
  reg [5:0] fault_m;
  reg [5:0] fault_s;
  reg [5:0] mask_m;
  reg [5:0] mask_s;
  reg       scl_m;
  reg       scl_s;
  reg       scl_d;
  reg       sda_m;
  reg       sda_s;
  reg       sda_d;

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_m <= 6'h00;
      fault_s <= 6'h00;
      mask_m  <= 6'h00;
      mask_s  <= 6'h00;
      scl_m   <= 1'b1;
      scl_s   <= 1'b1;
      scl_d   <= 1'b1;
      sda_m   <= 1'b1;
      sda_s   <= 1'b1;
      sda_d   <= 1'b1;
    end else begin
      fault_m <= diode_fault_i;
      fault_s <= fault_m;
      mask_m  <= ot_mask_i;
      mask_s  <= mask_m;
      scl_m   <= smb_clk_i;
      scl_s   <= scl_m;
      scl_d   <= scl_s;
      sda_m   <= smb_data_i;
      sda_s   <= sda_m;
      sda_d   <= sda_s;
    end
  end

  // per-channel flags
  wire [5:0] ot_flag;
  wire [5:0] fault_flag;

  genvar g;
  generate
    for (g = 0; g < `RDA_NCH; g = g + 1) begin : g_chan
      rda_chan u_chan (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .upd_i      (meas_done_i && (meas_chan_o == g + 1) && !meas_start_o),
        .temp_i     (meas_temp_i),
        .limit_i    (ot_limit_i[8*g +: 8]),
        .fault_i    (fault_s[g]),
        .ot_o       (ot_flag[g]),
        .fault_o    (fault_flag[g])
      );
    end
  endgenerate

  // status images; channels 2 and 3 have no overtemp bit
  wire [7:0] next_ot_status;
  wire [7:0] next_fault_status;
  assign next_ot_status    = {2'b00, ot_flag[5], ot_flag[4], ot_flag[3], 2'b00,
                              ot_flag[0]};
  assign next_fault_status = {1'b0, fault_flag, 1'b0};

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      overtemp_status_o    <= `RDA_STATUS_RST;
      diode_fault_status_o <= `RDA_STATUS_RST;
      overtemp_output_oe_o <= 1'b0;
    end else begin
      overtemp_status_o    <= next_ot_status;
      diode_fault_status_o <= next_fault_status;
      // only channels 1, 4, 5 and 6 own an overtemp output path
      overtemp_output_oe_o <= |(ot_flag & ~mask_s & 6'h39);
    end
  end

  // measurement sequencer: round robin over healthy channels
  reg  [1:0] sq_state;
  reg  [2:0] next_chan;
  reg        next_found;
  integer    k;
  integer    cand;

  always @* begin
    next_chan  = 3'd1;
    next_found = 1'b0;
    cand       = 0;
    for (k = `RDA_NCH; k >= 1; k = k - 1) begin
      cand = ((meas_chan_o + k - 1) % `RDA_NCH) + 1;
      if (!fault_flag[cand-1]) begin
        next_chan  = cand[2:0];
        next_found = 1'b1;
      end
    end
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sq_state     <= SQ_PICK;
      meas_chan_o  <= 3'd6;
      meas_start_o <= 1'b0;
    end else begin
      meas_start_o <= 1'b0;
      case (sq_state)
        SQ_PICK: begin
          // with every channel faulted the engine simply stays idle
          if (next_found) begin
            meas_chan_o  <= next_chan;
            meas_start_o <= 1'b1;
            sq_state     <= SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          if (meas_done_i && !meas_start_o) begin
            sq_state <= SQ_PICK;
          end
        end
        default: sq_state <= SQ_PICK;
      endcase
    end
  end

  // bus slave
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  reg [7:0] sb_state;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg [7:0] cmd;
  reg       rd_dir;
  reg       host_nack;
  reg [7:0] rd_data;

  always @* begin
    case (cmd)
      `RDA_CMD_OT:    rd_data = overtemp_status_o;
      `RDA_CMD_FAULT: rd_data = diode_fault_status_o;
      default:        rd_data = `RDA_UNMAPPED;
    endcase
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sb_state      <= SB_IDLE;
      shreg         <= 8'h00;
      bitcnt        <= 4'h0;
      cmd           <= 8'h00;
      rd_dir        <= 1'b0;
      host_nack     <= 1'b0;
      smb_data_oe_o <= 1'b0;
    end else if (bus_stop) begin
      sb_state      <= SB_IDLE;
      smb_data_oe_o <= 1'b0;
    end else if (bus_start) begin
      sb_state      <= SB_ADDR;
      bitcnt        <= 4'h0;
      smb_data_oe_o <= 1'b0;
    end else begin
      case (sb_state)
        SB_IDLE: smb_data_oe_o <= 1'b0;
        SB_ADDR, SB_WCMD: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            if (sb_state == SB_WCMD) begin
              cmd           <= shreg;
              smb_data_oe_o <= 1'b1;
              sb_state      <= SB_ACKC;
            end else if (shreg[7:1] == BUS_ADDR) begin
              rd_dir        <= shreg[0];
              smb_data_oe_o <= 1'b1;
              sb_state      <= SB_ACKA;
            end else begin
              sb_state <= SB_SKIP;
            end
          end
        end
        SB_ACKA: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            if (rd_dir) begin
              shreg         <= rd_data;
              smb_data_oe_o <= ~rd_data[7];
              sb_state      <= SB_RDAT;
            end else begin
              smb_data_oe_o <= 1'b0;
              sb_state      <= SB_WCMD;
            end
          end
        end
        SB_ACKC: begin
          // further written bytes only replace the command code
          if (scl_fall) begin
            bitcnt        <= 4'h0;
            smb_data_oe_o <= 1'b0;
            sb_state      <= SB_WCMD;
          end
        end
        SB_RDAT: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              smb_data_oe_o <= 1'b0;
              sb_state      <= SB_RACK;
            end else begin
              shreg         <= {shreg[6:0], 1'b0};
              smb_data_oe_o <= ~shreg[6];
            end
          end
        end
        SB_RACK: begin
          if (scl_rise) begin
            host_nack <= sda_s;
          end else if (scl_fall) begin
            bitcnt <= 4'h0;
            if (host_nack) begin
              sb_state <= SB_SKIP;
            end else begin
              shreg         <= rd_data;
              smb_data_oe_o <= ~rd_data[7];
              sb_state      <= SB_RDAT;
            end
          end
        end
        SB_SKIP: smb_data_oe_o <= 1'b0;
        default: begin
          sb_state      <= SB_IDLE;
          smb_data_oe_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- pkg/rda_map.vh ----
// Purpose: constants of the remote diode alarm status block
// Assumes: included by bare name from every design file
// Notes:   command codes that select the status registers are local choices
// How it works
// - channel 6 overtemp sets second-status bit 5
// - channel 5 overtemp sets second-status bit 4
// - channel 4 overtemp sets second-status bit 3
// - channel 1 overtemp sets second-status bit 0
// - diode fault of channel n sets third-status bit n
// - answer only the fixed seven-bit bus address
// - faulted channels are skipped by the measurement sequence
// - masked channels never drive the overtemp output
`ifndef RDA_MAP_VH
`define RDA_MAP_VH

// bus address variants
`define RDA_ADDR_V34     7'h1a
`define RDA_ADDR_V38     7'h1c
`define RDA_ADDR_V99     7'h4c
`define RDA_ADDR_V9C     7'h4e

// command codes that select a status register
`define RDA_CMD_OT       8'h12
`define RDA_CMD_FAULT    8'h1b

// overtemp status field positions
`define RDA_OT_BIT_CH6   5
`define RDA_OT_BIT_CH5   4
`define RDA_OT_BIT_CH4   3
`define RDA_OT_BIT_CH1   0

// fault status: channel n sits at bit n
`define RDA_NCH          6
`define RDA_STATUS_RST   8'h00
`define RDA_UNMAPPED     8'h00

`endif

// ---- src/rda_chan.v ----
// Purpose: one remote channel's overtemp and diode fault flags
// Assumes: fault_i already synchronised to core_clk_i
// Notes:   overtemp flag follows the latest completed measurement
`timescale 1ns/10ps
`include "rda_map.vh"

module rda_chan (
  input  wire       core_clk_i,
  input  wire       arst_n_i,
  input  wire       upd_i,
  input  wire [7:0] temp_i,
  input  wire [7:0] limit_i,
  input  wire       fault_i,
  output reg        ot_o,
  output reg        fault_o
);

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ot_o    <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      fault_o <= fault_i;
      // strictly above the limit counts as exceeding
      if (upd_i) begin
        ot_o <= (temp_i > limit_i);
      end
    end
  end

endmodule

// ---- test/rda_host.sv ----
// Purpose: bus host model that reads the status registers
// Assumes: open-drain data wire with pull-up, resolved by the bench
// Notes:   6 core cycles per phase, well above the 3-cycle pin sync lag
`timescale 1ns/10ps
module rda_host (
  input  wire core_clk_i,
  input  wire sda_i,
  output reg  scl_o = 1'b1,
  output reg  sda_low_o = 1'b0
);
  task automatic wt(input logic s, input logic d);
    repeat (6) @(posedge core_clk_i);
    #1 scl_o = s;
    sda_low_o = d;
  endtask
  // start from idle or as a repeated start after an ack slot
  task automatic st;
    wt(scl_o, 1'b0);
    wt(1'b1, 1'b0);
    wt(1'b1, 1'b1);
    wt(1'b0, 1'b1);
  endtask
  // ninth slot is released: it reads the ack, or sends a nack on reads
  task automatic xb(input [7:0] b, output [7:0] r, output logic ack);
    logic d;
    for (int i = 8; i >= 0; i--) begin
      d = (i > 0) ? b[i-1] : 1'b1;
      wt(1'b0, ~d);
      wt(1'b1, ~d);
      if (i > 0) r[i-1] = sda_i;
      else ack = ~sda_i;
      wt(1'b0, ~d);
    end
  endtask
  task automatic rd(input [6:0] a, input [7:0] cmd, output [7:0] dat, output logic ok);
    logic [7:0] x;
    logic k1, k2, k3, k4;
    st();
    xb({a, 1'b0}, x, k1);
    xb(cmd, x, k2);
    st();
    xb({a, 1'b1}, x, k3);
    xb(8'hff, dat, k4);
    ok = k1 & k2 & k3;
    wt(1'b0, 1'b1);
    wt(1'b1, 1'b1);
    wt(1'b1, 1'b0);
  endtask
endmodule

// ---- test/rda_top_assertions.sv ----
// Purpose: port-level checks of the status block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   latencies are those of the hand-over timing
`timescale 1ns/10ps
module rda_top_assertions (
  input wire        core_clk_i,
  input wire        arst_n_i,
  input wire        smb_clk_i,
  input wire        smb_data_i,
  input wire        smb_data_oe_o,
  input wire [5:0]  diode_fault_i,
  input wire [5:0]  ot_mask_i,
  input wire [47:0] ot_limit_i,
  input wire        meas_done_i,
  input wire [7:0]  meas_temp_i,
  input wire        meas_start_o,
  input wire [2:0]  meas_chan_o,
  input wire        overtemp_output_oe_o,
  input wire [7:0]  overtemp_status_o,
  input wire [7:0]  diode_fault_status_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire take = meas_done_i && !meas_start_o;
  property p_ot(c, b);
    take && meas_chan_o == c |-> ##2
      overtemp_status_o[b] == ($past(meas_temp_i, 2) > $past(ot_limit_i[8*c-8 +: 8], 2));
  endproperty
  chk_ot_ch1: assert property (p_ot(1, 0)) else $error("ch1 overtemp bit wrong");
  chk_ot_ch4: assert property (p_ot(4, 3)) else $error("ch4 overtemp bit wrong");
  chk_ot_ch5: assert property (p_ot(5, 4)) else $error("ch5 overtemp bit wrong");
  chk_ot_ch6: assert property (p_ot(6, 5)) else $error("ch6 overtemp bit wrong");
  chk_rsv_zero: assert property (overtemp_status_o[7:6] == 2'b00 &&
    overtemp_status_o[2:1] == 2'b00 && diode_fault_status_o[7] == 1'b0 &&
    diode_fault_status_o[0] == 1'b0) else $error("reserved status bit set");
  chk_fault_map: assert property ($stable(diode_fault_i) [*5] |->
    diode_fault_status_o[6:1] == diode_fault_i) else $error("fault bits do not follow");
  chk_fault_skip: assert property (meas_start_o |->
    !diode_fault_status_o[meas_chan_o] && meas_chan_o >= 1 && meas_chan_o <= 6)
    else $error("faulted or bad channel started");
  // a fault that lands while the next channel is picked legally changes the order
  chk_next_chan: assert property (take && diode_fault_status_o == 8'h00 |-> ##2
    (diode_fault_status_o != 8'h00 ||
     (meas_start_o && meas_chan_o == ($past(meas_chan_o, 2) % 6) + 1)))
    else $error("next channel not started in order");
  // mask passes a two-flop sync, so only settled masks are judged
  chk_oe_mask: assert property ($stable(ot_mask_i) [*4] |->
    overtemp_output_oe_o == |(overtemp_status_o[5:0] & ~ot_mask_i & 6'h39))
    else $error("overtemp output disagrees with masked flags");
  cov_equal: cover property (take && meas_temp_i == ot_limit_i[7:0] && meas_chan_o == 1);
  cov_skip: cover property (meas_start_o && diode_fault_status_o != 8'h00);
  cov_ack: cover property (smb_data_oe_o);
endmodule
bind rda_top rda_top_assertions u_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .smb_clk_i(smb_clk_i), .smb_data_i(smb_data_i), .smb_data_oe_o(smb_data_oe_o),
  .diode_fault_i(diode_fault_i), .ot_mask_i(ot_mask_i), .ot_limit_i(ot_limit_i),
  .meas_done_i(meas_done_i), .meas_temp_i(meas_temp_i), .meas_start_o(meas_start_o),
  .meas_chan_o(meas_chan_o), .overtemp_output_oe_o(overtemp_output_oe_o),
  .overtemp_status_o(overtemp_status_o), .diode_fault_status_o(diode_fault_status_o));

// ---- test/rda_top_tb.sv ----
// Purpose: self-checking bench of the status block
// Assumes: host model runs the bus, the bench plays the conversion engine
// Notes:   random limits and temperatures from a fixed seed
`timescale 1ns/10ps
`include "rda_map.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module rda_top_tb;
  logic       clk = 1'b0, rst_n = 1'b0, done = 1'b0, ok;
  logic [5:0] flt = 6'h00, msk = 6'h00;
  logic [7:0] tmp = 8'h00, dat, e, lims [1:6], temps [1:6];
  wire        sda, scl, sdl, st, oe_smb, ot_oe;
  wire [2:0]  ch;
  wire [7:0]  ots, fls;
  integer     fail_count = 0, checks_done = 0, k, c;
  always #5 clk = ~clk;
  assign sda = ~(sdl | oe_smb);
  rda_top uut (.core_clk_i(clk), .arst_n_i(rst_n), .smb_clk_i(scl), .smb_data_i(sda),
    .smb_data_oe_o(oe_smb), .diode_fault_i(flt), .ot_mask_i(msk),
    .ot_limit_i({lims[6], lims[5], lims[4], lims[3], lims[2], lims[1]}), .meas_done_i(done),
    .meas_temp_i(tmp), .meas_start_o(st), .meas_chan_o(ch), .overtemp_output_oe_o(ot_oe),
    .overtemp_status_o(ots), .diode_fault_status_o(fls));
  rda_host host (.core_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sdl));
  // conversion engine: answers five edges after each start
  always begin
    @(posedge clk);
    #1;
    if (st === 1'b1) begin
      repeat (4) @(posedge clk);
      #1 done = 1'b1;
      tmp = temps[ch];
      @(posedge clk);
      #1 done = 1'b0;
    end
  end
  function automatic [7:0] exp_ot();
    exp_ot = 8'h00;
    for (int i = 1; i <= 6; i++)
      if (i != 2 && i != 3 && temps[i] > lims[i]) exp_ot[i == 1 ? 0 : i - 1] = 1'b1;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #600000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(48811));
    for (c = 1; c <= 6; c++) begin
      lims[c] = 8'h80;
      temps[c] = 8'h00;
    end
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK("ot reset", 8'h00, ots)
    `CHK("fault reset", 8'h00, fls)
    // k 0 and 1 sit exactly on and just above each limit
    for (k = 0; k < 5; k++) begin
      for (c = 1; c <= 6; c++) begin
        lims[c] = 8'($urandom % 255);
        temps[c] = k == 0 ? lims[c] : k == 1 ? lims[c] + 8'h01 : 8'($urandom);
      end
      msk = k == 4 ? 6'h3f : 6'($urandom);
      repeat (150) @(posedge clk);
      #1 e = exp_ot();
      `CHK("ot status", e, ots)
      `CHK("ot output", |(e[5:0] & ~msk & 6'h39), ot_oe)
      host.rd(`RDA_ADDR_V99, `RDA_CMD_OT, dat, ok);
      `CHK("ot ack", 1'b1, ok)
      `CHK("ot read", e, dat)
    end
    flt = 6'($urandom) | 6'h01;
    repeat (20) @(posedge clk);
    #1 `CHK("fault status", {1'b0, flt, 1'b0}, fls)
    host.rd(`RDA_ADDR_V99, `RDA_CMD_FAULT, dat, ok);
    `CHK("fault read", {1'b0, flt, 1'b0}, dat)
    flt = 6'h3f;
    repeat (30) @(posedge clk);
    repeat (100) begin
      @(posedge clk);
      #1 `CHK("no start", 1'b0, st)
    end
    flt = 6'h00;
    host.rd(`RDA_ADDR_V34, `RDA_CMD_OT, dat, ok);
    `CHK("foreign ack", 1'b0, ok)
    `CHK("foreign data", 8'hff, dat)
    host.rd(`RDA_ADDR_V99, 8'h00, dat, ok);
    `CHK("unknown cmd", `RDA_UNMAPPED, dat)
    tally_and_finish();
  end
endmodule
